// >>> rtl/adc_sel_pkg.sv
//Contract
//R1 - PGA source bit picks pin or bandgap
//R2 - Bandgap choice disconnects PGA pin path
//R3 - Software enables bandgap first, waits start-up
//R4 - Reference code picks supply, pin, PGA
//R5 - Internal reference switches off reference pin
//R6 - Gain code selects 1, 1.667, 2.5, 3.333
//R7 - Bandgap register bit 0 enable, rest zero
//R8 - Software frees reference pin functions first
//R9 - Analog pin assignment disables digital function
//R10 - Analog pin assignment drops pull-high resistor
//R11 - Analog assignment overrides port direction
//R12 - External codes connect channel or float
//R13 - Codes 1-3 pick supply, half, quarter
//R14 - Codes 5-7 pick PGA, half, quarter
//R15 - Codes 10xx pick negative supply
//R16 - Internal signal switches off external path
//R17 - Bit 7 enables or powers down PGA
//R18 - Fields reset to zero, switches decoded
package adc_sel_pkg;
   // Bus shape
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int NUM_CH = 8;
   localparam int INT_W = 7;
   // Register offsets
   localparam logic [2:0] OFS_REF_PGA = 3'h0;
   localparam logic [2:0] OFS_BANDGAP = 3'h1;
   localparam logic [2:0] OFS_INPUT_SEL = 3'h2;
   localparam logic [2:0] OFS_PIN_FUNC_LO = 3'h3;
   localparam logic [2:0] OFS_PIN_FUNC_HI = 3'h4;
   localparam logic [2:0] OFS_PULL = 3'h5;
   localparam logic [2:0] OFS_DIR = 3'h6;
   localparam logic [2:0] OFS_STATUS = 3'h7;
   // Field positions
   localparam int RP_PGA_EN_BIT = 7;
   localparam int RP_PGA_SRC_BIT = 4;
   localparam int RP_REF_HI = 3;
   localparam int RP_REF_LO = 2;
   localparam int RP_GAIN_HI = 1;
   localparam int RP_GAIN_LO = 0;
   localparam int BG_EN_BIT = 0;
   localparam int IS_SRC_HI = 7;
   localparam int IS_SRC_LO = 4;
   localparam int IS_CHAN_HI = 3;
   localparam int IS_CHAN_LO = 0;
   // Reset values and writable masks
   localparam logic [7:0] REF_PGA_RST = 8'h00;
   localparam logic [7:0] BANDGAP_RST = 8'h00;
   localparam logic [7:0] INPUT_SEL_RST = 8'h00;
   localparam logic [7:0] PIN_FUNC_RST = 8'h00;
   localparam logic [7:0] PULL_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] REF_PGA_MASK = 8'h9f;
   localparam logic [7:0] BANDGAP_MASK = 8'h01;
   localparam logic [7:0] INPUT_SEL_MASK = 8'hff;
   // Pin function code for analog channel input
   localparam logic [1:0] PIN_FUNC_ANALOG = 2'h1;
   // Input source codes
   localparam logic [3:0] SRC_EXT_A = 4'h0;
   localparam logic [3:0] SRC_SUPPLY = 4'h1;
   localparam logic [3:0] SRC_SUPPLY_HALF = 4'h2;
   localparam logic [3:0] SRC_SUPPLY_QTR = 4'h3;
   localparam logic [3:0] SRC_EXT_B = 4'h4;
   localparam logic [3:0] SRC_PGA = 4'h5;
   localparam logic [3:0] SRC_PGA_HALF = 4'h6;
   localparam logic [3:0] SRC_PGA_QTR = 4'h7;
   localparam logic [1:0] SRC_GROUND_TOP = 2'h2;
   localparam logic [1:0] SRC_EXT_TOP = 2'h3;
   // Internal source one-hot positions
   localparam int INT_SUPPLY = 0;
   localparam int INT_SUPPLY_HALF = 1;
   localparam int INT_SUPPLY_QTR = 2;
   localparam int INT_PGA = 3;
   localparam int INT_PGA_HALF = 4;
   localparam int INT_PGA_QTR = 5;
   localparam int INT_GROUND = 6;
   // Reference and PGA codes
   localparam logic [1:0] REF_SUPPLY = 2'h0;
   localparam logic [1:0] REF_PIN = 2'h1;
   localparam logic PGA_SRC_PIN = 1'b0;
   localparam logic PGA_SRC_BANDGAP = 1'b1;
   localparam logic [1:0] GAIN_1 = 2'h0;
   localparam logic [1:0] GAIN_1P667 = 2'h1;
   localparam logic [1:0] GAIN_2P5 = 2'h2;
   localparam logic [1:0] GAIN_3P333 = 2'h3;
   // Status bits
   localparam int ST_EXT_PATH = 0;
   localparam int ST_INT_ANY = 1;
   localparam int ST_PGA_PIN = 2;
   localparam int ST_REF_PIN = 3;
   localparam int ST_CHAN_FLOAT = 4;
   localparam int ST_ANALOG_PINS = 5;
endpackage

// >>> rtl/adc_sel_if.sv
`timescale 1ns/1ps
interface adc_sel_if;
   import adc_sel_pkg::*;
   // Register contents
   logic [3:0] input_src_sel;
   logic [3:0] ext_chan_sel;
   logic pga_src_sel;
   logic [1:0] ref_src_sel;
   logic [NUM_CH-1:0] pin_func_sel_lo;
   logic [NUM_CH-1:0] pin_func_sel_hi;
   logic [NUM_CH-1:0] pull_sel;
   logic [NUM_CH-1:0] dir_sel;
   // Decoded switch controls
   logic ext_path;
   logic chan_float;
   logic [NUM_CH-1:0] chan_on;
   logic [INT_W-1:0] int_on;
   logic pga_from_pin;
   logic pga_from_bg;
   logic ref_supply;
   logic ref_pin;
   logic ref_pga;
   logic [NUM_CH-1:0] pin_analog;
   logic [NUM_CH-1:0] pin_digital;
   logic [NUM_CH-1:0] pin_pull;
   logic [NUM_CH-1:0] pin_oe;
   modport dec (
      input input_src_sel, ext_chan_sel, pga_src_sel, ref_src_sel,
      input pin_func_sel_lo, pin_func_sel_hi, pull_sel, dir_sel,
      output ext_path, chan_float, chan_on, int_on, pga_from_pin,
      output pga_from_bg, ref_supply, ref_pin, ref_pga,
      output pin_analog, pin_digital, pin_pull, pin_oe
   );
   modport ctl (
      output input_src_sel, ext_chan_sel, pga_src_sel, ref_src_sel,
      output pin_func_sel_lo, pin_func_sel_hi, pull_sel, dir_sel,
      input ext_path, chan_float, chan_on, int_on, pga_from_pin,
      input pga_from_bg, ref_supply, ref_pin, ref_pga,
      input pin_analog, pin_digital, pin_pull, pin_oe
   );
endinterface

// >>> rtl/adc_sel_decode.sv
`timescale 1ns/1ps
module adc_sel_decode
   import adc_sel_pkg::*;
(
   // Register side
   adc_sel_if.dec sel
);
   logic ext_sel;
   logic [INT_W-1:0] int_on;

   always_comb begin
      int_on = '0;
      case (sel.input_src_sel)
         SRC_SUPPLY: int_on[INT_SUPPLY] = 1'b1; // R13
         SRC_SUPPLY_HALF: int_on[INT_SUPPLY_HALF] = 1'b1; // R13
         SRC_SUPPLY_QTR: int_on[INT_SUPPLY_QTR] = 1'b1; // R13
         SRC_PGA: int_on[INT_PGA] = 1'b1; // R14
         SRC_PGA_HALF: int_on[INT_PGA_HALF] = 1'b1; // R14
         SRC_PGA_QTR: int_on[INT_PGA_QTR] = 1'b1; // R14
         default: begin
            if (sel.input_src_sel[3:2] == SRC_GROUND_TOP) begin
               int_on[INT_GROUND] = 1'b1; // R15
            end
         end
      endcase
   end

   // External path only for 0000, 0100, 11xx
   assign ext_sel = (sel.input_src_sel == SRC_EXT_A) ||
                    (sel.input_src_sel == SRC_EXT_B) ||
                    (sel.input_src_sel[3:2] == SRC_EXT_TOP); // R12 R16
   assign sel.int_on = int_on;
   assign sel.ext_path = ext_sel; // R16
   assign sel.chan_float = ext_sel & sel.ext_chan_sel[3]; // R12

   // Reference and PGA routing
   assign sel.pga_from_bg = (sel.pga_src_sel == PGA_SRC_BANDGAP); // R1
   assign sel.pga_from_pin = (sel.pga_src_sel == PGA_SRC_PIN); // R1 R2
   assign sel.ref_supply = (sel.ref_src_sel == REF_SUPPLY); // R4
   assign sel.ref_pin = (sel.ref_src_sel == REF_PIN); // R4 R5
   assign sel.ref_pga = sel.ref_src_sel[1]; // R4

   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++) begin : g_ch
         assign sel.chan_on[i] = ext_sel &&
            (sel.ext_chan_sel == 4'(i)); // R12 R16
         assign sel.pin_analog[i] = ({sel.pin_func_sel_hi[i],
            sel.pin_func_sel_lo[i]} == PIN_FUNC_ANALOG);
         assign sel.pin_digital[i] = ~sel.pin_analog[i]; // R9
         assign sel.pin_pull[i] = sel.pull_sel[i] &
            ~sel.pin_analog[i]; // R10
         assign sel.pin_oe[i] = sel.dir_sel[i] &
            ~sel.pin_analog[i]; // R11
      end
   endgenerate
endmodule // adc_sel_decode

// >>> rtl/adc_ref_input_select.sv
`timescale 1ns/1ps
module adc_ref_input_select
   import adc_sel_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [DATA_W-1:0] rd_data,
   // PGA and bandgap controls
   output logic pga_enable,
   output logic bandgap_en,
   output logic [1:0] pga_gain_sel,
   output logic pga_in_from_pin,
   output logic pga_in_from_bandgap,
   // Reference switches
   output logic ref_from_supply,
   output logic ref_from_pin,
   output logic ref_from_pga,
   // Converter input switches
   output logic ext_path_en,
   output logic [NUM_CH-1:0] chan_switch,
   output logic [INT_W-1:0] int_src_onehot,
   // Pin function controls
   output logic [NUM_CH-1:0] pin_analog,
   output logic [NUM_CH-1:0] pin_digital_en,
   output logic [NUM_CH-1:0] pin_pull_en,
   output logic [NUM_CH-1:0] pin_oe
);
   adc_sel_if sel ();

   adc_sel_decode u_decode (
      .sel (sel.dec)
   );

   // Register state
   logic [7:0] ref_pga_r, ref_pga_nxt;
   logic [7:0] bandgap_r, bandgap_nxt;
   logic [7:0] input_sel_r, input_sel_nxt;
   logic [7:0] func_lo_r, func_lo_nxt;
   logic [7:0] func_hi_r, func_hi_nxt;
   logic [7:0] pull_r, pull_nxt;
   logic [7:0] dir_r, dir_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic [7:0] status;

   always_comb begin
      ref_pga_nxt = ref_pga_r;
      bandgap_nxt = bandgap_r;
      input_sel_nxt = input_sel_r;
      func_lo_nxt = func_lo_r;
      func_hi_nxt = func_hi_r;
      pull_nxt = pull_r;
      dir_nxt = dir_r;
      if (wr_en) begin
         case (addr)
            OFS_REF_PGA: ref_pga_nxt = wr_data & REF_PGA_MASK; // R17
            OFS_BANDGAP: bandgap_nxt = wr_data & BANDGAP_MASK; // R7
            OFS_INPUT_SEL: input_sel_nxt = wr_data & INPUT_SEL_MASK;
            OFS_PIN_FUNC_LO: func_lo_nxt = wr_data;
            OFS_PIN_FUNC_HI: func_hi_nxt = wr_data;
            OFS_PULL: pull_nxt = wr_data;
            OFS_DIR: dir_nxt = wr_data;
            default: ;
         endcase
      end
   end

   // Live routing state for software
   always_comb begin
      status = '0;
      status[ST_EXT_PATH] = sel.ext_path;
      status[ST_INT_ANY] = |sel.int_on;
      status[ST_PGA_PIN] = sel.pga_from_pin;
      status[ST_REF_PIN] = sel.ref_pin;
      status[ST_CHAN_FLOAT] = sel.chan_float;
      status[ST_ANALOG_PINS] = |sel.pin_analog;
   end

   // Read data only in the cycle after the strobe
   always_comb begin
      rd_data_nxt = '0;
      if (rd_en) begin
         case (addr)
            OFS_REF_PGA: rd_data_nxt = ref_pga_r;
            OFS_BANDGAP: rd_data_nxt = bandgap_r; // R7
            OFS_INPUT_SEL: rd_data_nxt = input_sel_r;
            OFS_PIN_FUNC_LO: rd_data_nxt = func_lo_r;
            OFS_PIN_FUNC_HI: rd_data_nxt = func_hi_r;
            OFS_PULL: rd_data_nxt = pull_r;
            OFS_DIR: rd_data_nxt = dir_r;
            OFS_STATUS: rd_data_nxt = status;
            default: rd_data_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ref_pga_r <= REF_PGA_RST; // R18
         bandgap_r <= BANDGAP_RST; // R7
         input_sel_r <= INPUT_SEL_RST; // R18
         func_lo_r <= PIN_FUNC_RST;
         func_hi_r <= PIN_FUNC_RST;
         pull_r <= PULL_RST;
         dir_r <= DIR_RST;
         rd_data_r <= '0;
      end else begin
         ref_pga_r <= ref_pga_nxt;
         bandgap_r <= bandgap_nxt;
         input_sel_r <= input_sel_nxt;
         func_lo_r <= func_lo_nxt;
         func_hi_r <= func_hi_nxt;
         pull_r <= pull_nxt;
         dir_r <= dir_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   // Fields to the decoder
   assign sel.input_src_sel = input_sel_r[IS_SRC_HI:IS_SRC_LO];
   assign sel.ext_chan_sel = input_sel_r[IS_CHAN_HI:IS_CHAN_LO];
   assign sel.pga_src_sel = ref_pga_r[RP_PGA_SRC_BIT];
   assign sel.ref_src_sel = ref_pga_r[RP_REF_HI:RP_REF_LO];
   assign sel.pin_func_sel_lo = func_lo_r;
   assign sel.pin_func_sel_hi = func_hi_r;
   assign sel.pull_sel = pull_r;
   assign sel.dir_sel = dir_r;

   // Output registers
   logic pga_en_r, pga_en_nxt;
   logic bg_en_r, bg_en_nxt;
   logic [1:0] gain_r, gain_nxt;
   logic pga_pin_r, pga_pin_nxt;
   logic pga_bg_r, pga_bg_nxt;
   logic ref_sup_r, ref_sup_nxt;
   logic ref_pin_r, ref_pin_nxt;
   logic ref_pga_out_r, ref_pga_out_nxt;
   logic ext_path_r, ext_path_nxt;
   logic [NUM_CH-1:0] chan_r, chan_nxt;
   logic [INT_W-1:0] int_r, int_nxt;
   logic [NUM_CH-1:0] pan_r, pan_nxt;
   logic [NUM_CH-1:0] pdig_r, pdig_nxt;
   logic [NUM_CH-1:0] ppull_r, ppull_nxt;
   logic [NUM_CH-1:0] poe_r, poe_nxt;

   always_comb begin
      pga_en_nxt = ref_pga_r[RP_PGA_EN_BIT]; // R17
      bg_en_nxt = bandgap_r[BG_EN_BIT]; // R7
      gain_nxt = ref_pga_r[RP_GAIN_HI:RP_GAIN_LO]; // R6
      pga_pin_nxt = sel.pga_from_pin; // R2
      pga_bg_nxt = sel.pga_from_bg; // R1
      ref_sup_nxt = sel.ref_supply; // R4
      ref_pin_nxt = sel.ref_pin; // R5
      ref_pga_out_nxt = sel.ref_pga; // R4
      ext_path_nxt = sel.ext_path; // R16
      chan_nxt = sel.chan_on; // R12
      int_nxt = sel.int_on; // R13 R14 R15
      pan_nxt = sel.pin_analog;
      pdig_nxt = sel.pin_digital; // R9
      ppull_nxt = sel.pin_pull; // R10
      poe_nxt = sel.pin_oe; // R11
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pga_en_r <= 1'b0;
         bg_en_r <= 1'b0;
         gain_r <= GAIN_1;
         pga_pin_r <= 1'b1;
         pga_bg_r <= 1'b0;
         ref_sup_r <= 1'b1;
         ref_pin_r <= 1'b0;
         ref_pga_out_r <= 1'b0;
         ext_path_r <= 1'b1;
         chan_r <= 8'h01;
         int_r <= '0;
         pan_r <= '0;
         pdig_r <= '1;
         ppull_r <= '0;
         poe_r <= '0;
      end else begin
         pga_en_r <= pga_en_nxt;
         bg_en_r <= bg_en_nxt;
         gain_r <= gain_nxt;
         pga_pin_r <= pga_pin_nxt;
         pga_bg_r <= pga_bg_nxt;
         ref_sup_r <= ref_sup_nxt;
         ref_pin_r <= ref_pin_nxt;
         ref_pga_out_r <= ref_pga_out_nxt;
         ext_path_r <= ext_path_nxt;
         chan_r <= chan_nxt;
         int_r <= int_nxt;
         pan_r <= pan_nxt;
         pdig_r <= pdig_nxt;
         ppull_r <= ppull_nxt;
         poe_r <= poe_nxt;
      end
   end

   assign rd_data = rd_data_r;
   assign pga_enable = pga_en_r;
   assign bandgap_en = bg_en_r;
   assign pga_gain_sel = gain_r;
   assign pga_in_from_pin = pga_pin_r;
   assign pga_in_from_bandgap = pga_bg_r;
   assign ref_from_supply = ref_sup_r;
   assign ref_from_pin = ref_pin_r;
   assign ref_from_pga = ref_pga_out_r;
   assign ext_path_en = ext_path_r;
   assign chan_switch = chan_r;
   assign int_src_onehot = int_r;
   assign pin_analog = pan_r;
   assign pin_digital_en = pdig_r;
   assign pin_pull_en = ppull_r;
   assign pin_oe = poe_r;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   logic [1:0] wr_gain;
   logic [3:0] src_now;
   assign wr_gain = wr_data[1:0];
   assign src_now = input_sel_r[IS_SRC_HI:IS_SRC_LO];

   sequence wr_ref_s;
      wr_en && addr == OFS_REF_PGA;
   endsequence
   sequence wr_ref_alone_s;
      wr_ref_s ##1 !(wr_en && addr == OFS_REF_PGA);
   endsequence

   pga_route_a: assert property ( // R1
      ##1 pga_in_from_bandgap == $past(ref_pga_r[RP_PGA_SRC_BIT]))
      else $error("PGA input route does not follow source bit");
   pga_pin_off_a: assert property ( // R2
      pga_in_from_bandgap |-> !pga_in_from_pin)
      else $error("PGA pin path on with bandgap selected");
   ref_sel_a: assert property ( // R4
      ##1 $onehot({ref_from_supply, ref_from_pin, ref_from_pga}) &&
      ref_from_pga == $past(ref_pga_r[RP_REF_HI]))
      else $error("Reference select decode wrong");
   ref_pin_off_a: assert property ( // R5
      (ref_from_supply || ref_from_pga) |-> !ref_from_pin)
      else $error("Reference pin on with internal reference");
   gain_write_a: assert property ( // R6
      wr_ref_alone_s |-> ##1 pga_gain_sel == $past(wr_gain, 2))
      else $error("PGA gain does not follow written code");
   bandgap_read_a: assert property ( // R7
      rd_en && addr == OFS_BANDGAP |=>
      rd_data[7:1] == 7'h00 && rd_data[0] == bandgap_en)
      else $error("Bandgap register read wrong");
   pin_func_a: assert property ( // R9
      pin_analog == ~pin_digital_en)
      else $error("Digital function left on for analog pin");
   pull_off_a: assert property ( // R10
      (pin_analog & pin_pull_en) == 8'h00)
      else $error("Pull-high on for analog pin");
   dir_override_a: assert property ( // R11
      (pin_analog & pin_oe) == 8'h00)
      else $error("Output driver on for analog pin");
   chan_map_a: assert property ( // R12
      ext_path_nxt && !input_sel_r[IS_CHAN_HI] |=>
      chan_switch == 8'h01 << $past(input_sel_r[2:0]))
      else $error("External channel switch wrong");
   supply_src_a: assert property ( // R13
      src_now == SRC_SUPPLY_QTR |=> int_src_onehot == 7'h04)
      else $error("Quarter supply not selected");
   pga_src_a: assert property ( // R14
      src_now == SRC_PGA_HALF |=> int_src_onehot == 7'h10)
      else $error("Half PGA output not selected");
   ground_src_a: assert property ( // R15
      src_now[3:2] == SRC_GROUND_TOP |=>
      int_src_onehot == 7'h40 && chan_switch == 8'h00)
      else $error("Negative supply not selected");
   ext_off_a: assert property ( // R16
      (|int_src_onehot) |-> !ext_path_en && chan_switch == 8'h00)
      else $error("External path on with internal source");
   pga_enable_a: assert property ( // R17
      ##1 pga_enable == $past(ref_pga_r[RP_PGA_EN_BIT]))
      else $error("PGA enable does not follow bit 7");
   rd_idle_a: assert property ( // R18
      !rd_en |=> rd_data == 8'h00)
      else $error("Read data not zero outside read cycle");
   bandgap_follow_a: assert property ( // R7
      ##1 bandgap_en == $past(bandgap_r[BG_EN_BIT]))
      else $error("Bandgap enable does not follow bit 0");
   ref_reserved_a: assert property ( // R17
      ref_pga_r[6:5] == 2'h0)
      else $error("Unused reference control bits set");
   chan_float_a: assert property ( // R12
      ext_path_nxt && input_sel_r[IS_CHAN_HI] |=> chan_switch == 8'h00)
      else $error("Channel switch closed for missing channel");
   supply_full_a: assert property ( // R13
      src_now == SRC_SUPPLY |=> int_src_onehot == 7'h01)
      else $error("Full supply not selected");
   pga_full_a: assert property ( // R14
      src_now == SRC_PGA |=> int_src_onehot == 7'h08)
      else $error("Full PGA output not selected");
endmodule // adc_ref_input_select

// >>> dv/adc_ref_input_select_tb.sv
`timescale 1ns/1ps
module adc_ref_input_select_tb;
   import adc_sel_pkg::*;
   // Clock and reset
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   // Register port
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wr_data = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [DATA_W-1:0] rd_data;
   // Outputs
   logic pga_enable, bandgap_en, pga_in_from_pin, pga_in_from_bandgap;
   logic [1:0] pga_gain_sel;
   logic ref_from_supply, ref_from_pin, ref_from_pga, ext_path_en;
   logic [NUM_CH-1:0] chan_switch, pin_analog, pin_digital_en;
   logic [NUM_CH-1:0] pin_pull_en, pin_oe;
   logic [INT_W-1:0] int_src_onehot;
   // Shadow copies of the register file
   logic [7:0] sh [0:6];
   int err_total = 0;
   int comparisons = 0;
   int seed_dummy;

   adc_ref_input_select dut_u (
      .mclk(mclk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .pga_enable(pga_enable), .bandgap_en(bandgap_en),
      .pga_gain_sel(pga_gain_sel), .pga_in_from_pin(pga_in_from_pin),
      .pga_in_from_bandgap(pga_in_from_bandgap),
      .ref_from_supply(ref_from_supply), .ref_from_pin(ref_from_pin),
      .ref_from_pga(ref_from_pga), .ext_path_en(ext_path_en),
      .chan_switch(chan_switch), .int_src_onehot(int_src_onehot),
      .pin_analog(pin_analog), .pin_digital_en(pin_digital_en),
      .pin_pull_en(pin_pull_en), .pin_oe(pin_oe)
   );

   always #2 mclk = ~mclk;

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what,
                  got, exp);
      end
   endtask

   // Expected decode from the shadow registers
   function automatic logic ext_sel(input logic [3:0] s);
      return (s == SRC_EXT_A) || (s == SRC_EXT_B) || (s[3:2] == 2'h3);
   endfunction

   function automatic logic [6:0] int_exp(input logic [3:0] s);
      case (s)
         4'h1: return 7'h01;
         4'h2: return 7'h02;
         4'h3: return 7'h04;
         4'h5: return 7'h08;
         4'h6: return 7'h10;
         4'h7: return 7'h20;
         4'h8, 4'h9, 4'ha, 4'hb: return 7'h40;
         default: return 7'h00;
      endcase
   endfunction

   function automatic logic [7:0] chan_exp(input logic [7:0] is);
      if (ext_sel(is[7:4]) && !is[3]) begin
         return 8'h01 << is[2:0];
      end
      return 8'h00;
   endfunction

   function automatic logic [7:0] analog_exp();
      return ~sh[4] & sh[3];
   endfunction

   function automatic logic [7:0] status_exp();
      logic [7:0] st;
      st = 8'h00;
      st[ST_EXT_PATH] = ext_sel(sh[2][7:4]);
      st[ST_INT_ANY] = |int_exp(sh[2][7:4]);
      st[ST_PGA_PIN] = ~sh[0][4];
      st[ST_REF_PIN] = (sh[0][3:2] == 2'h1);
      st[ST_CHAN_FLOAT] = ext_sel(sh[2][7:4]) && sh[2][3];
      st[ST_ANALOG_PINS] = |analog_exp();
      return st;
   endfunction

   task automatic check_outs();
      logic [7:0] an;
      an = analog_exp();
      cmp({7'h00, pga_enable}, {7'h00, sh[0][7]}, "pga enable");
      cmp({7'h00, bandgap_en}, {7'h00, sh[1][0]}, "bandgap");
      cmp({6'h00, pga_gain_sel}, {6'h00, sh[0][1:0]}, "gain");
      cmp({7'h00, pga_in_from_pin}, {7'h00, ~sh[0][4]}, "pga pin");
      cmp({7'h00, pga_in_from_bandgap}, {7'h00, sh[0][4]}, "pga bg");
      cmp({5'h00, ref_from_supply, ref_from_pin, ref_from_pga},
          {5'h00, sh[0][3:2] == 2'h0, sh[0][3:2] == 2'h1, sh[0][3]},
          "reference");
      cmp({7'h00, ext_path_en}, {7'h00, ext_sel(sh[2][7:4])},
          "ext path");
      cmp(chan_switch, chan_exp(sh[2]), "channel");
      cmp({1'b0, int_src_onehot}, {1'b0, int_exp(sh[2][7:4])},
          "internal src");
      cmp(pin_analog, an, "pin analog");
      cmp(pin_digital_en, ~an, "pin digital");
      cmp(pin_pull_en, sh[5] & ~an, "pull high");
      cmp(pin_oe, sh[6] & ~an, "direction");
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
      if (a == OFS_REF_PGA) sh[0] = d & REF_PGA_MASK;
      else if (a == OFS_BANDGAP) sh[1] = d & BANDGAP_MASK;
      else if (a != OFS_STATUS) sh[a] = d;
   endtask

   task automatic rd(input logic [2:0] a);
      logic [7:0] exp;
      @(posedge mclk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      exp = (a == OFS_STATUS) ? status_exp() : sh[a];
      #1;
      cmp(rd_data, exp, "read data");
      @(posedge mclk);
      #1;
      cmp(rd_data, 8'h00, "read idle");
   endtask

   // Write, let outputs settle, then compare everything
   task automatic wr_check(input logic [2:0] a, input logic [7:0] d);
      wr(a, d);
      @(posedge mclk);
      #1;
      check_outs();
      rd(a);
      rd(OFS_STATUS);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #40000;
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end

   initial begin
      for (int i = 0; i < 7; i++) sh[i] = 8'h00;
      seed_dummy = $urandom(58308);
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      #1;
      check_outs();
      for (int i = 0; i < 8; i++) rd(i[2:0]);
      // Reserved bits and the read-only status
      wr_check(OFS_REF_PGA, 8'hff);
      wr_check(OFS_BANDGAP, 8'hff);
      repeat (8) @(posedge mclk);
      wr_check(OFS_STATUS, 8'hff);
      // PGA source, reference and gain codes
      wr(OFS_PIN_FUNC_LO, 8'h00);
      for (int i = 0; i < 32; i++) begin
         wr_check(OFS_REF_PGA, {i[4], 2'h0, i[4:0]});
      end
      // Every input source code, channel in and out of range
      for (int i = 0; i < 16; i++) begin
         wr_check(OFS_INPUT_SEL, {i[3:0], i[3:0]});
         wr_check(OFS_INPUT_SEL, {i[3:0], 4'hf - i[3:0]});
      end
      // Pin function overrides pull and direction
      wr(OFS_PULL, 8'hff);
      wr(OFS_DIR, 8'hff);
      wr_check(OFS_PIN_FUNC_HI, 8'h0f);
      wr_check(OFS_PIN_FUNC_LO, 8'h55);
      // Random traffic over all writable registers
      for (int i = 0; i < 60; i++) begin
         wr_check(3'($urandom_range(0, 6)), 8'($urandom));
      end
      // Second reset in mid-run
      @(posedge mclk);
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      for (int i = 0; i < 7; i++) sh[i] = 8'h00;
      #1;
      check_outs();
      rd(OFS_STATUS);
      end_of_test();
   end
endmodule // adc_ref_input_select_tb
